// ---- design/noise_update_map.vh ----
`ifndef NOISE_UPDATE_MAP_VH
`define NOISE_UPDATE_MAP_VH
// ==========================================
// Register word offsets (byte address)
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_VMETRIC      8'h08
`define OFS_BURST        8'h0C
`define OFS_PITCH_GAIN   8'h10
`define OFS_SNR_FRAME    8'h14
`define OFS_SNR_PEAK     8'h18
`define OFS_DEVIATION    8'h1C
`define OFS_ETOT         8'h20
`define OFS_SNR_INIT     8'h24
`define OFS_ALPHA        8'h28
// Channel arrays: base plus four times the channel index
`define BASE_ENERGY      2'h1
`define BASE_NOISE       2'h2
`define BASE_AVG         2'h3
// ==========================================
// Control and status fields
`define CTRL_START       0
`define CTRL_RESTART     1
`define ST_BUSY          0
`define ST_DONE          1
`define ST_UPDATE        2
`define ST_FUPDATE       3
`define ST_TONE          4
`define ST_PITCH         5
`define ST_REINIT        6
// ==========================================
// Sizes
`define NUM_CH           16
`define LAST_CH          4'hF
`define FIRST_TONE_CH    4'h2
// ==========================================
// Limits, all dB values in Q8
`define TEN_DB           16'h0A00
`define SNR_INIT_BASE    16'h3800
`define ALPHA_HIGH       9'h0FD
`define ALPHA_LOW        9'h0B3
`define ALPHA_NOISE      9'h0E6
`define ALPHA_ONE        9'h100
`define E_MIN            16'h0010
`define E_INIT           16'h0010
`define NOISE_FLOOR      20'h00200
`define METRIC_LIMIT     16'h0023
`define FORCED_LIMIT     8'h32
`define STALL_LIMIT      8'h06
`define DEV_LIMIT        20'h01C00
`define PITCH_LIMIT      16'h00A6
`define INIT_FRAMES      8'h04
`define DB_PER_OCTAVE    10'h303
`endif

// ---- design/energy_to_db.v ----
`timescale 1ns/1ps
`default_nettype none
module energy_to_db (
   // Linear energy in
   input  wire [23:0] i_energy,
   // Ten log10 of it, Q8 dB
   output reg  [15:0] o_db
);
`include "noise_update_map.vh"
   reg [4:0]  msb;
   reg [23:0] norm;
   reg [12:0] log2_q8;
   reg [22:0] prod;
   integer    k;
   // ==========================================
   // Log2 by leading one plus linear fraction, scaled to dB
   always @* begin
      msb = 5'h00;
      for (k = 0; k < 24; k = k + 1) begin
         if (i_energy[k]) begin
            msb = k[4:0];
         end
      end
      norm    = i_energy << (5'h17 - msb);
      log2_q8 = {msb, norm[22:15]};
      prod    = log2_q8 * `DB_PER_OCTAVE;
      o_db    = (i_energy == 24'h000000) ? 16'h0000 : {1'b0, prod[22:8]};  // Product stays below 2^23
   end
endmodule // energy_to_db
`default_nettype wire

// ---- design/noise_update_decision.v ----
`timescale 1ns/1ps
`default_nettype none
module noise_update_decision (
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_sys_rst,
   // Wishbone slave
   input  wire        i_wb_cyc,
   input  wire        i_wb_stb,
   input  wire        i_wb_we,
   input  wire [7:0]  i_wb_adr,
   input  wire [31:0] i_wb_dat,
   input  wire [3:0]  i_wb_sel,
   output reg  [31:0] o_wb_dat,
   output reg         o_wb_ack,
   // Decision results
   output reg         o_valid,
   output reg         o_update_flag,
   output reg         o_fupdate_flag,
   output reg         o_tone_flag,
   output reg         o_variability_clear
);
`include "noise_update_map.vh"
   // ==========================================
   // States
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_PASS1  = 3'h1;
   localparam [2:0] S_LMAX   = 3'h2;
   localparam [2:0] S_LMEAN  = 3'h3;
   localparam [2:0] S_LNS    = 3'h4;
   localparam [2:0] S_DECIDE = 3'h5;
   localparam [2:0] S_PASS2  = 3'h6;
   localparam [2:0] S_DONE   = 3'h7;
   // ==========================================
   // Storage
   reg [15:0] energy_reg [0:`NUM_CH-1];
   reg [15:0] noise_reg  [0:`NUM_CH-1];
   reg [15:0] avg_reg    [0:`NUM_CH-1];
   reg [15:0] cur_db_reg [0:`NUM_CH-1];
   reg [2:0]  state_reg;
   reg [3:0]  ch_reg;
   reg [7:0]  frame_reg;
   reg [15:0] vmetric_reg;
   reg [15:0] burst_reg;
   reg [15:0] pitch_reg;
   reg [15:0] snr_frame_reg;
   reg [15:0] snr_peak_reg;
   reg [19:0] dev_reg;
   reg [19:0] etot_reg;
   reg [19:0] nsum_reg;
   reg [15:0] emax_reg;
   reg [15:0] dbmax_reg;
   reg [15:0] snr_init_reg;
   reg [8:0]  alpha_reg;
   reg [7:0]  cnt_reg;
   reg [7:0]  last_cnt_reg;
   reg [7:0]  stall_reg;
   reg        upd_reg;
   reg        fupd_reg;
   reg        tone_reg;
   reg        pitch_flag_reg;
   reg        reinit_reg;
   reg        done_reg;
   reg [31:0] rdata;
   reg [23:0] conv_in;
   wire [15:0] conv_db;
   integer     n;
   // ==========================================
   // Helpers
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] dat;
      input [3:0]  sel;
      begin
         merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      end
   endfunction
   function [15:0] blend;
      input [8:0]  a;
      input [15:0] old;
      input [15:0] cur;
      reg   [25:0] s;
      begin
         s     = a * old + (`ALPHA_ONE - a) * cur;
         blend = s[23:8];
      end
   endfunction
   function [15:0] max16;
      input [15:0] a;
      input [15:0] b;
      begin
         max16 = (a > b) ? a : b;
      end
   endfunction
   // ==========================================
   // Shared log converter
   always @* begin
      case (state_reg)
         S_PASS1: conv_in = {8'h00, energy_reg[ch_reg]};
         S_LMAX:  conv_in = {8'h00, emax_reg};
         S_LMEAN: conv_in = {8'h00, etot_reg[19:4]};
         S_LNS:   conv_in = {4'h0, nsum_reg};
         default: conv_in = 24'h000000;
      endcase
   end
   energy_to_db u_db (
      .i_energy (conv_in),
      .o_db     (conv_db)
   );
   // ==========================================
   // Subframe flags and arithmetic
   wire        first_sub = (frame_reg == 8'h00);                         // Subframe m = 1
   wire        early_sub = (frame_reg < `INIT_FRAMES);                   // Subframes m <= 4
   wire [15:0] avg_now   = avg_reg[ch_reg];
   wire [15:0] db_diff   = (conv_db > avg_now) ? conv_db - avg_now : avg_now - conv_db;
   wire [15:0] e_now     = energy_reg[ch_reg];
   // Smoothing factor from peak and frame SNR
   reg signed [31:0] a_hi;
   reg signed [31:0] a_lo;
   reg signed [31:0] snr_f;
   reg signed [31:0] snr_p;
   reg signed [31:0] a_num;
   reg signed [31:0] a_raw;
   reg [8:0]         alpha_next;
   always @* begin
      a_hi  = {23'h000000, `ALPHA_HIGH};
      a_lo  = {23'h000000, `ALPHA_LOW};
      snr_f = {{16{snr_frame_reg[15]}}, snr_frame_reg};
      snr_p = {{16{snr_peak_reg[15]}}, snr_peak_reg};
      a_num = (a_hi - a_lo) * (snr_p - snr_f);
      // A peak SNR at or below zero selects the low limit and avoids a zero divide
      a_raw      = (snr_p > 32'sd0) ? a_hi - a_num / snr_p : a_lo;
      alpha_next = (a_raw > a_hi) ? `ALPHA_HIGH : (a_raw < a_lo) ? `ALPHA_LOW : a_raw[8:0];
   end
   // Refresh decision
   reg       upd_next;
   reg       fupd_next;
   reg [7:0] cnt_next;
   reg [7:0] stall_next;
   reg       pflag_next;
   always @* begin
      upd_next   = 1'b0;
      fupd_next  = 1'b0;
      cnt_next   = cnt_reg;
      pflag_next = (pitch_reg > `PITCH_LIMIT);
      if ((vmetric_reg <= `METRIC_LIMIT) && (burst_reg == 16'h0000)) begin
         upd_next = 1'b1;
         cnt_next = 8'h00;
      end else if ((etot_reg > `NOISE_FLOOR) && (dev_reg < `DEV_LIMIT) &&
                   !tone_reg && !pflag_next) begin
         cnt_next = cnt_reg + 8'h01;
         if (cnt_next >= `FORCED_LIMIT) begin
            upd_next  = 1'b1;
            fupd_next = 1'b1;
         end
      end
      stall_next = (cnt_next == last_cnt_reg) ? stall_reg + 8'h01 : 8'h00;
   end
   // ==========================================
   // Register file and processing sequence
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_reg      <= S_IDLE;
         frame_reg      <= 8'h00;
         vmetric_reg    <= 16'h0000;
         burst_reg      <= 16'h0000;
         pitch_reg      <= 16'h0000;
         snr_frame_reg  <= 16'h0000;
         snr_peak_reg   <= 16'h0000;
         dev_reg        <= 20'h00000;
         etot_reg       <= 20'h00000;
         snr_init_reg   <= 16'h0000;
         alpha_reg      <= `ALPHA_HIGH;
         cnt_reg        <= 8'h00;
         last_cnt_reg   <= 8'h00;
         stall_reg      <= 8'h00;
         upd_reg        <= 1'b0;
         fupd_reg       <= 1'b0;
         tone_reg       <= 1'b0;
         pitch_flag_reg <= 1'b0;
         reinit_reg     <= 1'b0;
         done_reg       <= 1'b0;
         o_valid        <= 1'b0;
         for (n = 0; n < `NUM_CH; n = n + 1) begin
            energy_reg[n] <= `E_INIT;
            noise_reg[n]  <= `E_INIT;
            avg_reg[n]    <= 16'h0000;
         end
      end else begin
         o_valid <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               // Inputs are accepted only between runs
               if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack) begin
                  if (i_wb_adr[7:6] == `BASE_ENERGY) begin
                     energy_reg[i_wb_adr[5:2]] <= merge16(energy_reg[i_wb_adr[5:2]], i_wb_dat, i_wb_sel);
                  end
                  case (i_wb_adr)
                     `OFS_VMETRIC:    vmetric_reg   <= merge16(vmetric_reg, i_wb_dat, i_wb_sel);
                     `OFS_BURST:      burst_reg     <= merge16(burst_reg, i_wb_dat, i_wb_sel);
                     `OFS_PITCH_GAIN: pitch_reg     <= merge16(pitch_reg, i_wb_dat, i_wb_sel);
                     `OFS_SNR_FRAME:  snr_frame_reg <= merge16(snr_frame_reg, i_wb_dat, i_wb_sel);
                     `OFS_SNR_PEAK:   snr_peak_reg  <= merge16(snr_peak_reg, i_wb_dat, i_wb_sel);
                     `OFS_CTRL: begin
                        if (i_wb_sel[0] && i_wb_dat[`CTRL_RESTART]) begin
                           frame_reg    <= 8'h00;
                           cnt_reg      <= 8'h00;
                           last_cnt_reg <= 8'h00;
                           stall_reg    <= 8'h00;
                        end else if (i_wb_sel[0] && i_wb_dat[`CTRL_START]) begin
                           state_reg <= S_PASS1;
                           ch_reg    <= 4'h0;
                           dev_reg   <= 20'h00000;
                           etot_reg  <= 20'h00000;
                           nsum_reg  <= 20'h00000;
                           emax_reg  <= 16'h0000;
                           done_reg  <= 1'b0;
                        end
                     end
                     default: ;
                  endcase
               end
            end
            S_PASS1: begin
               cur_db_reg[ch_reg] <= conv_db;
               if (first_sub) begin
                  avg_reg[ch_reg] <= conv_db;
               end else begin
                  dev_reg <= dev_reg + {4'h0, db_diff};
               end
               etot_reg <= etot_reg + {4'h0, e_now};
               nsum_reg <= nsum_reg + {4'h0, noise_reg[ch_reg]};
               if ((ch_reg >= `FIRST_TONE_CH) && (e_now > emax_reg)) begin
                  emax_reg <= e_now;
               end
               if (ch_reg == `LAST_CH) begin
                  state_reg <= S_LMAX;
               end
               ch_reg <= ch_reg + 4'h1;
            end
            S_LMAX: begin
               dbmax_reg <= conv_db;
               state_reg <= S_LMEAN;
            end
            S_LMEAN: begin
               tone_reg  <= (dbmax_reg > conv_db) && ((dbmax_reg - conv_db) > `TEN_DB);
               state_reg <= S_LNS;
            end
            S_LNS: begin
               snr_init_reg <= `SNR_INIT_BASE - conv_db;
               state_reg    <= S_DECIDE;
            end
            S_DECIDE: begin
               upd_reg        <= upd_next;
               fupd_reg       <= fupd_next;
               pitch_flag_reg <= pflag_next;
               last_cnt_reg   <= cnt_next;
               stall_reg      <= stall_next;
               cnt_reg        <= (stall_next > `STALL_LIMIT) ? 8'h00 : cnt_next;
               reinit_reg     <= fupd_next || early_sub;
               alpha_reg      <= alpha_next;
               ch_reg         <= 4'h0;
               state_reg      <= S_PASS2;
            end
            S_PASS2: begin
               // On the first subframe both blend inputs are equal, so the loaded average stays
               avg_reg[ch_reg] <= blend(alpha_reg, avg_reg[ch_reg], cur_db_reg[ch_reg]);
               if (early_sub) begin
                  noise_reg[ch_reg] <= max16(`E_INIT, e_now);
               end else if (upd_reg) begin
                  noise_reg[ch_reg] <= max16(`E_MIN, blend(`ALPHA_NOISE, noise_reg[ch_reg], e_now));
               end
               if (ch_reg == `LAST_CH) begin
                  state_reg <= S_DONE;
               end
               ch_reg <= ch_reg + 4'h1;
            end
            S_DONE: begin
               if (reinit_reg) begin
                  snr_frame_reg <= snr_init_reg;
                  snr_peak_reg  <= snr_init_reg;
               end
               if (frame_reg != 8'hFF) begin
                  frame_reg <= frame_reg + 8'h01;
               end
               done_reg  <= 1'b1;
               o_valid   <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
   // ==========================================
   // Result outputs, loaded with the valid strobe
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_update_flag       <= 1'b0;
         o_fupdate_flag      <= 1'b0;
         o_tone_flag         <= 1'b0;
         o_variability_clear <= 1'b0;
      end else if (state_reg == S_DONE) begin
         o_update_flag       <= upd_reg;
         o_fupdate_flag      <= fupd_reg;
         o_tone_flag         <= tone_reg;
         o_variability_clear <= reinit_reg;
      end
   end
   // ==========================================
   // Read data decode
   always @* begin
      rdata = 32'h00000000;
      case (i_wb_adr[7:6])
         `BASE_ENERGY: rdata = {16'h0000, energy_reg[i_wb_adr[5:2]]};
         `BASE_NOISE:  rdata = {16'h0000, noise_reg[i_wb_adr[5:2]]};
         `BASE_AVG:    rdata = {16'h0000, avg_reg[i_wb_adr[5:2]]};
         default: begin
            case (i_wb_adr)
               `OFS_STATUS:     rdata = {16'h0000, cnt_reg, 1'b0, reinit_reg, pitch_flag_reg, tone_reg,
                                         fupd_reg, upd_reg, done_reg, (state_reg != S_IDLE)};
               `OFS_VMETRIC:    rdata = {16'h0000, vmetric_reg};
               `OFS_BURST:      rdata = {16'h0000, burst_reg};
               `OFS_PITCH_GAIN: rdata = {16'h0000, pitch_reg};
               `OFS_SNR_FRAME:  rdata = {16'h0000, snr_frame_reg};
               `OFS_SNR_PEAK:   rdata = {16'h0000, snr_peak_reg};
               `OFS_DEVIATION:  rdata = {12'h000, dev_reg};
               `OFS_ETOT:       rdata = {12'h000, etot_reg};
               `OFS_SNR_INIT:   rdata = {16'h0000, snr_init_reg};
               `OFS_ALPHA:      rdata = {23'h000000, alpha_reg};
               default:         rdata = 32'h00000000;
            endcase
         end
      endcase
   end
   // ==========================================
   // Wishbone acknowledge, one cycle after the strobe
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
         o_wb_dat <= rdata;
      end
   end
endmodule // noise_update_decision
`default_nettype wire

// ---- test/noise_update_decision_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module noise_update_decision_asserts (
   // Clock and reset
   input wire logic        i_core_clk,
   input wire logic        i_sys_rst,
   // Wishbone slave
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   // Decision results
   input wire logic        o_valid,
   input wire logic        o_update_flag,
   input wire logic        o_fupdate_flag,
   input wire logic        o_tone_flag,
   input wire logic        o_variability_clear
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // ==========================================
   // Start request seen while no run is active
   logic run_reg;
   wire  start_req = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && (i_wb_adr[7:2] == 6'h00)
                     && i_wb_sel[0] && i_wb_dat[0] && !i_wb_dat[1] && !run_reg;
   // Tracks a run from its start write to its strobe
   always @(posedge i_core_clk) begin
      if (i_sys_rst) run_reg <= 1'b0;
      else if (start_req) run_reg <= 1'b1;
      else if (o_valid) run_reg <= 1'b0;
   end
   sequence s_start; start_req; endsequence
   sequence s_quiet; !o_valid [*8]; endsequence
   // ==========================================
   // Properties
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
   a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("request not acked");
   a_ack_cause: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
   a_run_latency: assert property (s_start |-> ##38 o_valid) else $error("strobe late or missing");
   a_run_quiet: assert property (s_start |=> s_quiet) else $error("early strobe");
   a_valid_cause: assert property (o_valid |-> run_reg) else $error("strobe without run");
   a_flags_at_valid: assert property (!$past(i_sys_rst)
      && !$stable({o_update_flag, o_fupdate_flag, o_tone_flag, o_variability_clear})
      |-> o_valid) else $error("flags moved without strobe");
   a_forced_both: assert property (o_fupdate_flag |-> o_update_flag) else $error("forced without refresh");
   a_forced_reinit: assert property (o_fupdate_flag |-> o_variability_clear) else $error("forced no reinit");
   a_reset_clear: assert property (disable iff (1'b0) i_sys_rst |=> !o_valid && !o_update_flag
      && !o_fupdate_flag && !o_tone_flag && !o_wb_ack) else $error("outputs not cleared");
endmodule // noise_update_decision_asserts
bind noise_update_decision noise_update_decision_asserts u_chk (
   .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack), .o_valid(o_valid), .o_update_flag(o_update_flag), .o_fupdate_flag(o_fupdate_flag),
   .o_tone_flag(o_tone_flag), .o_variability_clear(o_variability_clear));
`default_nettype wire

// ---- test/front_end_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
   // Channel query
   input  wire logic [3:0]  i_ch,
   input  wire logic [15:0] i_level,
   input  wire logic        i_peak_on,
   input  wire logic [3:0]  i_peak_ch,
   // Pitch predictor
   input  wire logic [15:0] i_gain,
   output logic      [15:0] o_energy,
   output logic      [15:0] o_gain
);
   // Flat energy floor with one optional peak 256 times higher
   assign o_energy = (i_peak_on && i_ch == i_peak_ch) ? {i_level[7:0], 8'h00} : i_level;
   // Prediction gain of the previous frame, handed on unchanged
   assign o_gain = i_gain;
endmodule // front_end_model
`default_nettype wire

// ---- test/noise_update_decision_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "noise_update_map.vh"
module noise_update_decision_bench;
   logic        i_core_clk = 0, i_sys_rst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
   logic [7:0]  i_wb_adr = 0;
   logic [31:0] i_wb_dat = 0, q;
   logic [3:0]  i_wb_sel = 4'hF, m_ch = 0, m_pk_ch = 0;
   logic [15:0] m_level = 0, m_gain = 0, energy, gain;
   logic        m_pk_on = 0;
   wire  [31:0] o_wb_dat;
   wire         o_wb_ack, o_valid, o_update_flag, o_fupdate_flag, o_tone_flag, o_variability_clear;
   int          failures = 0, num_checks = 0;
   typedef struct {logic on; logic [3:0] ch; logic [15:0] gain, metric, burst; logic tone, pitch, upd;} row_t;
   row_t rows [4] = '{'{1'b1, 4'h5, `PITCH_LIMIT, `METRIC_LIMIT, 16'h0, 1'b1, 1'b0, 1'b1},
                      '{1'b1, 4'h1, `PITCH_LIMIT + 16'h1, `METRIC_LIMIT, 16'h1, 1'b0, 1'b1, 1'b0},
                      '{1'b1, 4'h2, 16'h0, `METRIC_LIMIT + 16'h1, 16'h0, 1'b1, 1'b0, 1'b0},
                      '{1'b0, 4'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 1'b1}};
   // ==========================================
   // Design and far side
   noise_update_decision u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_valid(o_valid), .o_update_flag(o_update_flag),
      .o_fupdate_flag(o_fupdate_flag), .o_tone_flag(o_tone_flag), .o_variability_clear(o_variability_clear));
   front_end_model u_model (.i_ch(m_ch), .i_level(m_level), .i_peak_on(m_pk_on), .i_peak_ch(m_pk_ch),
      .i_gain(m_gain), .o_energy(energy), .o_gain(gain));
   // Clock
   always #50 i_core_clk = ~i_core_clk;
   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      // Only the watchdog ends a wait that never sees ack
      do begin
         @(posedge i_core_clk);
      end while (o_wb_ack !== 1'b1);
      q = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // Start one subframe and wait for its strobe
   task automatic run();
      int n;
      wb(1'b1, `OFS_CTRL, 32'h1);
      n = 0;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_valid !== 1'b1 && n < 100);
      chk(n < 100, 1'b1);
   endtask
   task automatic load(input logic [15:0] lvl, metric, burst);
      m_level = lvl;
      for (int c = 0; c < 16; c++) begin
         m_ch = 4'(c);
         #1;
         wb(1'b1, 8'h40 + 8'(4 * c), {16'h0, energy});
      end
      wb(1'b1, `OFS_VMETRIC, {16'h0, metric});
      wb(1'b1, `OFS_BURST, {16'h0, burst});
      wb(1'b1, `OFS_PITCH_GAIN, {16'h0, gain});
   endtask
   task automatic cnt_chk(input logic [7:0] exp);
      wb(1'b0, `OFS_STATUS, 32'h0);
      chk(q[15:8], exp);
   endtask
   task automatic results();
      $display("Checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      rd_chk(`OFS_STATUS, 32'h0);
      rd_chk(8'h80, `E_INIT);
      rd_chk(8'h30, 32'h0);
      foreach (rows[i]) begin
         m_pk_on = rows[i].on;
         m_pk_ch = rows[i].ch;
         m_gain = rows[i].gain;
         load(16'h10, rows[i].metric, rows[i].burst);
         run();
         chk(o_tone_flag, rows[i].tone);
         chk(o_update_flag, rows[i].upd);
         wb(1'b0, `OFS_STATUS, 32'h0);
         chk(q[`ST_PITCH], rows[i].pitch);
      end
      // Restart, then a quiet stationary input that counts towards a forced refresh
      wb(1'b1, `OFS_CTRL, 32'h2);
      m_pk_on = 1'b0;
      m_gain = 16'h0;
      load(16'h40, 16'h100, 16'h0);
      run();
      chk(o_variability_clear, 1'b1);
      rd_chk(`OFS_DEVIATION, 32'h0);
      rd_chk(`OFS_ETOT, 32'h400);
      rd_chk(8'h8C, 32'h40);
      rd_chk(8'hC0, 32'(6 * `DB_PER_OCTAVE));
      rd_chk(`OFS_ALPHA, {23'h0, `ALPHA_HIGH});
      cnt_chk(8'h01);
      repeat (48) run();
      cnt_chk(8'h31);
      chk({o_fupdate_flag, o_variability_clear}, 2'b00);
      run();
      chk({o_fupdate_flag, o_update_flag, o_variability_clear}, 3'b111);
      // Negative frame SNR against a small peak drives the factor below its low limit
      wb(1'b1, `OFS_SNR_FRAME, 32'hFF00);
      wb(1'b1, `OFS_SNR_PEAK, 32'h0100);
      // Pitch gain holds the counter still until the stall limit clears it
      wb(1'b1, `OFS_PITCH_GAIN, 32'h100);
      repeat (6) run();
      cnt_chk(8'h32);
      rd_chk(`OFS_ALPHA, {23'h0, `ALPHA_LOW});
      run();
      cnt_chk(8'h00);
      // Reset in mid-run clears the counters
      wb(1'b1, `OFS_CTRL, 32'h1);
      i_sys_rst <= 1'b1;
      @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      rd_chk(`OFS_STATUS, 32'h0);
      results();
   end
   // Watchdog
   initial begin
      repeat (30000) @(posedge i_core_clk);
      failures++;
      results();
   end
endmodule // noise_update_decision_bench
`default_nettype wire
